/* File: rtl/uart_port.sv */
/*
 * serial port core: transmitter, receiver with majority vote and
 * address filter, sticky done flags and the combined request.
 * assumes software strobes are one-cycle pulses and rxd is synchronous.
 */
`timescale 1ns/1ps
module uart_port (
    input  wire logic       ref_clk,
    input  wire logic       rst,
    input  wire logic [1:0] frame_mode,
    input  wire logic       receive_enable,
    input  wire logic       address_filter_enable,
    input  wire logic       double_rate,
    input  wire logic       use_timer2,
    input  wire logic       timer1_ovf,
    input  wire logic       timer2_ovf,
    input  wire logic       transmit_ninth_bit,
    input  wire logic       buffer_write,
    input  wire logic [7:0] buffer_write_data,
    input  wire logic       receive_done_clear,
    input  wire logic       transmit_done_clear,
    input  wire logic       rxd,
    output logic            txd,
    output logic [7:0]      serial_data_buffer,
    output logic            received_ninth_bit,
    output logic            receive_done_flag,
    output logic            transmit_done_flag,
    output logic            serial_irq,
    output logic            sending
);
    // ------------------------------------------------------------
    // rate enable
    // ------------------------------------------------------------
    uart_tick_if ticks ();

    uart_rate_select u_rate (
        .ref_clk     (ref_clk),
        .rst         (rst),
        .frame_mode  (frame_mode),
        .double_rate (double_rate),
        .timer1_ovf  (timer1_ovf),
        .timer2_ovf  (timer2_ovf),
        .use_timer2  (use_timer2),
        .ticks       (ticks.source)
    );

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        // transmitter
        logic [3:0]            tx_div;    // free divide-by-16 counter
        logic                  tx_req;    // write pending start
        logic                  tx_send;   // frame in progress
        logic                  tx_data;   // shift output on line
        logic [3:0]            tx_bit;    // bit times since start
        logic [8:0]            tx_shift;  // nine-position shift register
        logic                  tx_stop_in; // stop bit not yet inserted
        logic                  txd;       // line level
        // receiver
        uart_pkg::rx_state_t   rx_state;  // receive control state
        logic [3:0]            rx_div;    // receive divide-by-16 counter
        logic [8:0]            rx_shift;  // input shift register
        logic [2:0]            rx_votes;  // samples of current bit
        logic                  rx_prev;   // last 16x sample of line
        logic                  rx_first;  // first bit time pending
        // software view
        logic [7:0]            buf_data;  // receive buffer
        logic                  ninth;     // received ninth bit
        logic                  ri;        // receive done
        logic                  ti;        // transmit done
        logic                  irq;       // combined request
    } port_state_t;

    port_state_t s_reg;   // registered state
    port_state_t s_next;  // next state

    logic eleven;         // 11-bit frame in force
    logic tx_roll;        // transmit counter rollover
    logic rx_bit_end;     // receive bit boundary
    logic vote;           // majority result
    logic load_ok;        // filter conditions met
    logic set_ri;         // receive flag set this cycle
    logic set_ti;         // transmit flag set this cycle

    // next-state logic for whole port
    always_comb begin
        s_next     = s_reg;
        set_ri     = 1'b0;
        set_ti     = 1'b0;
        eleven     = frame_mode[1];
        tx_roll    = ticks.tx_tick && (s_reg.tx_div == uart_pkg::PHASE_LAST);
        rx_bit_end = ticks.rx_tick && (s_reg.rx_div == uart_pkg::PHASE_LAST);
        vote       = (s_reg.rx_votes[0] & s_reg.rx_votes[1])
                   | (s_reg.rx_votes[1] & s_reg.rx_votes[2])
                   | (s_reg.rx_votes[0] & s_reg.rx_votes[2]);
        load_ok    = 1'b0;

        // --------------------------------------------------------
        // transmitter
        // --------------------------------------------------------
        if (ticks.tx_tick) begin
            s_next.tx_div = s_reg.tx_div + 4'h1;
        end
        if (buffer_write && !s_reg.tx_send) begin
            // ninth position: stop bit for 10-bit, programmed bit for 11-bit
            s_next.tx_shift = {eleven ? transmit_ninth_bit : 1'b1,
                               buffer_write_data};
            s_next.tx_req   = 1'b1;
        end
        if (tx_roll && s_reg.tx_req) begin
            // bit times follow the free counter, not the write
            s_next.tx_req     = 1'b0;
            s_next.tx_send    = 1'b1;
            s_next.tx_data    = 1'b0;
            s_next.tx_bit     = 4'h1;
            s_next.tx_stop_in = eleven;
            s_next.txd        = 1'b0;
        end else if (tx_roll && s_reg.tx_send) begin
            s_next.tx_bit = s_reg.tx_bit + 4'h1;
            if (!s_reg.tx_data) begin
                s_next.tx_data = 1'b1;
                s_next.txd     = s_reg.tx_shift[0];
            end else begin
                // first shift puts the stop bit in (11-bit only; the 10-bit stop bit is loaded at the write); then zeros
                s_next.tx_shift   = {s_reg.tx_stop_in, s_reg.tx_shift[8:1]};
                s_next.tx_stop_in = 1'b0;
                s_next.txd        = s_reg.tx_stop_in ? s_reg.tx_shift[1]
                                  : (s_reg.tx_shift[8:1] == 8'h00 ? 1'b1
                                                                  : s_reg.tx_shift[1]);
                // tx_bit counts rollovers since the write, so this edge is the next one
                if (s_reg.tx_bit + 4'h1 == (eleven ? uart_pkg::TX_BITS_ELEV
                                                   : uart_pkg::TX_BITS_TEN)) begin
                    // last shift: line idles high
                    s_next.tx_send = 1'b0;
                    s_next.tx_data = 1'b0;
                    s_next.txd     = 1'b1;
                    set_ti         = 1'b1;
                end
            end
        end

        // --------------------------------------------------------
        // receiver
        // --------------------------------------------------------
        if (ticks.rx_tick) begin
            s_next.rx_prev = rxd;
        end
        case (s_reg.rx_state)
            uart_pkg::RX_IDLE: begin
                // edge search only while enabled
                if (receive_enable && ticks.rx_tick && s_reg.rx_prev && !rxd) begin
                    s_next.rx_state = uart_pkg::RX_SHIFT;
                    s_next.rx_div   = 4'h0;
                    s_next.rx_shift = uart_pkg::RX_PRESET;
                    s_next.rx_first = 1'b1;
                end
            end
            uart_pkg::RX_SHIFT: begin
                if (ticks.rx_tick) begin
                    s_next.rx_div = s_reg.rx_div + 4'h1;
                    if (s_reg.rx_div == uart_pkg::SAMPLE_A) begin
                        s_next.rx_votes[0] = rxd;
                    end
                    if (s_reg.rx_div == uart_pkg::SAMPLE_B) begin
                        s_next.rx_votes[1] = rxd;
                    end
                    if (s_reg.rx_div == uart_pkg::SAMPLE_C) begin
                        s_next.rx_votes[2] = rxd;
                    end
                end
                if (rx_bit_end) begin
                    s_next.rx_first = 1'b0;
                    if (s_reg.rx_first && vote) begin
                        s_next.rx_state = uart_pkg::RX_IDLE;
                    end else if (!s_reg.rx_shift[8]) begin
                        // final shift: this bit is the stop bit (10-bit) or ninth bit
                        load_ok = receive_enable && !s_reg.ri
                                  && (!address_filter_enable || vote);
                        if (load_ok) begin
                            // first data bit sits highest: reverse so it lands in bit 0
                            s_next.buf_data = {s_reg.rx_shift[0], s_reg.rx_shift[1],
                                               s_reg.rx_shift[2], s_reg.rx_shift[3],
                                               s_reg.rx_shift[4], s_reg.rx_shift[5],
                                               s_reg.rx_shift[6], s_reg.rx_shift[7]};
                            s_next.ninth    = vote;
                            set_ri          = 1'b1;
                        end
                        s_next.rx_state = eleven ? uart_pkg::RX_HOLD
                                                 : uart_pkg::RX_IDLE;
                    end else begin
                        s_next.rx_shift = {s_reg.rx_shift[7:0], vote};
                    end
                end
            end
            uart_pkg::RX_HOLD: begin
                // one more bit time before the search resumes
                if (ticks.rx_tick) begin
                    s_next.rx_div = s_reg.rx_div + 4'h1;
                end
                if (rx_bit_end) begin
                    s_next.rx_state = uart_pkg::RX_IDLE;
                end
            end
            default: begin
                s_next.rx_state = uart_pkg::RX_IDLE;
            end
        endcase
        if (!receive_enable) begin
            s_next.rx_state  = uart_pkg::RX_IDLE;
        end

        // --------------------------------------------------------
        // sticky flags: a set wins over a clear in the same cycle
        // --------------------------------------------------------
        s_next.ri  = set_ri | (s_reg.ri & ~receive_done_clear);
        s_next.ti  = set_ti | (s_reg.ti & ~transmit_done_clear);
        s_next.irq = s_next.ri | s_next.ti;
    end

    // register all state
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            s_reg          <= '0;
            s_reg.txd      <= 1'b1;
            s_reg.rx_prev  <= 1'b1;
            s_reg.rx_state <= uart_pkg::RX_IDLE;
        end else begin
            s_reg <= s_next;
        end
    end

    // ------------------------------------------------------------
    // outputs straight from flip-flops
    // ------------------------------------------------------------
    assign txd                = s_reg.txd;
    assign serial_data_buffer = s_reg.buf_data;
    assign received_ninth_bit = s_reg.ninth;
    assign receive_done_flag  = s_reg.ri;
    assign transmit_done_flag = s_reg.ti;
    assign serial_irq         = s_reg.irq;
    assign sending            = s_reg.tx_send;
endmodule : uart_port

/* File: rtl/uart_pkg.sv */
/*
 * constants and receiver states for the asynchronous serial port
 * (10-bit and 11-bit frame modes).
 * assumes one 50 MHz clock; rate ticks come in as one-cycle enable pulses.
 */
package uart_pkg;

    // ------------------------------------------------------------
    // frame modes
    // ------------------------------------------------------------
    localparam logic [1:0] MODE_TEN      = 2'h1;  // 10-bit frame, timer rate
    localparam logic [1:0] MODE_ELEVEN_F = 2'h2;  // 11-bit frame, fixed rate
    localparam logic [1:0] MODE_ELEVEN_V = 2'h3;  // 11-bit frame, timer rate

    // ------------------------------------------------------------
    // counts
    // ------------------------------------------------------------
    localparam logic [3:0] SAMPLE_A      = 4'h6;  // 7th counter state
    localparam logic [3:0] SAMPLE_B      = 4'h7;  // 8th counter state
    localparam logic [3:0] SAMPLE_C      = 4'h8;  // 9th counter state
    localparam logic [3:0] PHASE_LAST    = 4'hf;  // rollover state
    localparam logic [8:0] RX_PRESET     = 9'h1ff; // shift register preset
    localparam logic [3:0] TX_BITS_TEN   = 4'ha;  // rollovers, 10-bit frame
    localparam logic [3:0] TX_BITS_ELEV  = 4'hb;  // rollovers, 11-bit frame
    localparam logic [4:0] FIXED_DIV_LO  = 5'h01; // 16x tick every cycle, /16 rate
    localparam logic [4:0] FIXED_DIV_HI  = 5'h02; // every second cycle, /32 rate

    // receiver states
    typedef enum logic [1:0] {RX_IDLE, RX_SHIFT, RX_HOLD} rx_state_t;

endpackage : uart_pkg

/* File: rtl/uart_tick_if.sv */
/*
 * carries the 16x rate enable from the rate block to the port core.
 * assumes both ends share ref_clk.
 */
`timescale 1ns/1ps
interface uart_tick_if;
    logic tx_tick;   // 16x transmit rate enable
    logic rx_tick;   // 16x receive rate enable
    modport source (output tx_tick, output rx_tick);
    modport sink   (input  tx_tick, input  rx_tick);
endinterface : uart_tick_if

/* File: rtl/uart_rate_select.sv */
/*
 * picks the 16x sampling enable per mode: cpu clock /1 or /2 for the
 * fixed-rate mode, timer overflow pulses otherwise.
 * assumes timer overflow inputs are one-cycle pulses on ref_clk.
 */
`timescale 1ns/1ps
module uart_rate_select (
    input  wire logic       ref_clk,
    input  wire logic       rst,
    input  wire logic [1:0] frame_mode,
    input  wire logic       double_rate,
    input  wire logic       timer1_ovf,
    input  wire logic       timer2_ovf,
    input  wire logic       use_timer2,
    uart_tick_if.source     ticks
);
    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        logic [4:0] div;   // fixed-rate prescaler
        logic       tick;  // registered enable
    } rate_state_t;

    rate_state_t s_reg;    // registered state
    rate_state_t s_next;   // next state
    logic [4:0]  limit;    // prescale limit

    // next-state logic
    always_comb begin
        s_next = s_reg;
        limit  = double_rate ? uart_pkg::FIXED_DIV_LO : uart_pkg::FIXED_DIV_HI;
        s_next.tick = 1'b0;
        if (frame_mode == uart_pkg::MODE_ELEVEN_F) begin
            // fixed rate: divider on the cpu clock
            if (s_reg.div + 5'h01 >= limit) begin
                s_next.div  = 5'h00;
                s_next.tick = 1'b1;
            end else begin
                s_next.div = s_reg.div + 5'h01;
            end
        end else if (frame_mode == uart_pkg::MODE_TEN) begin
            s_next.tick = use_timer2 ? timer2_ovf : timer1_ovf;
        end else begin
            s_next.tick = timer1_ovf;
        end
    end

    // register
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    assign ticks.tx_tick = s_reg.tick;
    assign ticks.rx_tick = s_reg.tick;
endmodule : uart_rate_select

/* File: tb/uart_port_props.sv */
/* checker for the serial port top: flag, line and timing relations.
   assumes it is bound onto uart_port, with ref_clk and rst its only domain. */
`timescale 1ns/1ps
module uart_port_props (
    input wire logic       ref_clk,
    input wire logic       rst,
    input wire logic [1:0] frame_mode,
    input wire logic       receive_enable,
    input wire logic       address_filter_enable,
    input wire logic       double_rate,
    input wire logic       buffer_write,
    input wire logic       transmit_done_clear,
    input wire logic       receive_done_clear,
    input wire logic       txd,
    input wire logic [7:0] serial_data_buffer,
    input wire logic       received_ninth_bit,
    input wire logic       receive_done_flag,
    input wire logic       transmit_done_flag,
    input wire logic       serial_irq,
    input wire logic       sending
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);
    // -----
    // assertions
    // -----
    irq_merge_a: assert property (serial_irq == (receive_done_flag | transmit_done_flag))
        else $error("request is not the or of the flags");
    tx_sticky_a: assert property (transmit_done_flag && !transmit_done_clear |=> transmit_done_flag)
        else $error("transmit flag dropped without clear");
    rx_sticky_a: assert property (receive_done_flag && !receive_done_clear |=> receive_done_flag)
        else $error("receive flag dropped without clear");
    // fast fixed rate: a bit is 16 clocks, so any low run lasts at least 8
    tx_bit_width_a: assert property ($fell(txd) && frame_mode == uart_pkg::MODE_ELEVEN_F
        && double_rate |-> !txd [*8])
        else $error("low bit shorter than a bit time");
    tx_stop_flag_a: assert property ($rose(transmit_done_flag) |-> txd)
        else $error("transmit flag set while line low");
    tx_start_a: assert property (buffer_write && !sending && double_rate
        && frame_mode == uart_pkg::MODE_ELEVEN_F |-> ##[1:40] (sending && !txd))
        else $error("start bit missing after write");
    rx_filter_a: assert property ($rose(receive_done_flag)
        |-> !address_filter_enable || received_ninth_bit)
        else $error("filtered frame was loaded");
    rx_enabled_a: assert property ($rose(receive_done_flag) |-> receive_enable)
        else $error("frame loaded while receive disabled");
    rx_hold_a: assert property ($changed(serial_data_buffer) || $changed(received_ninth_bit)
        |-> $rose(receive_done_flag))
        else $error("buffer changed without a load");
    // -----
    // main scenarios seen
    // -----
    tx_done_c: cover property ($rose(transmit_done_flag));
    rx_filt_c: cover property ($rose(receive_done_flag) && address_filter_enable);
    tx_busy_c: cover property (sending && buffer_write);
endmodule : uart_port_props

bind uart_port uart_port_props u_props (
    .ref_clk(ref_clk), .rst(rst), .frame_mode(frame_mode), .receive_enable(receive_enable),
    .address_filter_enable(address_filter_enable), .double_rate(double_rate),
    .buffer_write(buffer_write), .transmit_done_clear(transmit_done_clear),
    .receive_done_clear(receive_done_clear), .txd(txd), .serial_data_buffer(serial_data_buffer),
    .received_ninth_bit(received_ninth_bit), .receive_done_flag(receive_done_flag),
    .transmit_done_flag(transmit_done_flag), .serial_irq(serial_irq), .sending(sending));

/* File: tb/remote_serial.sv */
/* far-end serial transceiver: sends frames into the port, captures its output.
   assumes a bit time of cpb clocks of ref_clk, idle line high. */
`timescale 1ns/1ps
module remote_serial (
    input  wire logic       ref_clk,
    input  wire logic       txd,
    input  wire logic [7:0] cpb,
    output logic            rxd
);
    initial rxd = 1'b1;  // line pulled high while idle
    // -----
    // send n bits lsb first; hit_at flips one clock of bit 1 (noise)
    // -----
    task automatic send(input int n, input logic [10:0] f, input int hit_at);
        int k;
        int c;
        for (k = 0; k < n; k++) begin
            for (c = 0; c < cpb; c++) begin
                rxd <= (k == 1 && c == hit_at) ? ~f[k] : f[k];
                @(posedge ref_clk);
            end
        end
        rxd <= 1'b1;
    endtask : send
    // capture n bits from the falling start edge, sampled mid-bit
    task automatic recv(input int n, output logic [10:0] f);
        int k;
        f = 11'h000;
        @(negedge txd);
        repeat (cpb / 2) @(posedge ref_clk);
        for (k = 0; k < n; k++) begin
            f[k] = txd;
            repeat (cpb) @(posedge ref_clk);
        end
    endtask : recv
endmodule : remote_serial

/* File: tb/tb_top.sv */
/* self-checking bench for uart_port: all modes, filter, overrun, noise.
   assumes remote_serial as the far end; timer 1 pulses every second clock,
   timer 2 every clock. */
`timescale 1ns/1ps
module tb_top;
    logic        ref_clk = 1'b0;
    logic        rst = 1'b1;
    logic [1:0]  frame_mode = 2'h2;
    logic        receive_enable = 1'b1;
    logic        address_filter_enable = 1'b0;
    logic        double_rate = 1'b1;
    logic        use_timer2 = 1'b0;
    logic        timer1_ovf = 1'b0;
    logic        timer2_ovf = 1'b0;
    logic        transmit_ninth_bit = 1'b0;
    logic        buffer_write = 1'b0;
    logic [7:0]  buffer_write_data = 8'h00;
    logic        receive_done_clear = 1'b0;
    logic        transmit_done_clear = 1'b0;
    logic        rxd, txd, received_ninth_bit, receive_done_flag;
    logic        transmit_done_flag, serial_irq, sending;
    logic [7:0]  serial_data_buffer;
    logic [7:0]  cpb = 8'h10;          // clocks per bit for the far end
    logic [31:0] rnd = 32'h0000000f;   // xorshift state
    logic [8:0]  exp_rx = 9'h000;      // what the port should be holding
    logic [3:0]  cfg_tab [5] = '{4'ha, 4'h8, 4'hc, 4'h4, 4'h5}; // mode, double, timer2
    int          fails = 0;
    int          cmp_count = 0;
    always #10 ref_clk = ~ref_clk;
    // timer 1: bit of 32 clocks; timer 2: bit of 16 clocks, so the source choice shows
    always @(posedge ref_clk) begin
        timer1_ovf <= ~timer1_ovf;
        timer2_ovf <= 1'b1;
    end
    uart_port u_dut (.ref_clk(ref_clk), .rst(rst), .frame_mode(frame_mode),
        .receive_enable(receive_enable), .address_filter_enable(address_filter_enable),
        .double_rate(double_rate), .use_timer2(use_timer2), .timer1_ovf(timer1_ovf),
        .timer2_ovf(timer2_ovf), .transmit_ninth_bit(transmit_ninth_bit),
        .buffer_write(buffer_write), .buffer_write_data(buffer_write_data),
        .receive_done_clear(receive_done_clear), .transmit_done_clear(transmit_done_clear),
        .rxd(rxd), .txd(txd), .serial_data_buffer(serial_data_buffer),
        .received_ninth_bit(received_ninth_bit), .receive_done_flag(receive_done_flag),
        .transmit_done_flag(transmit_done_flag), .serial_irq(serial_irq), .sending(sending));
    remote_serial u_remote (.ref_clk(ref_clk), .txd(txd), .cpb(cpb), .rxd(rxd));
    // -----
    // helpers
    // -----
    function automatic logic [31:0] next_rand();
        rnd = rnd ^ (rnd << 13);
        rnd = rnd ^ (rnd >> 17);
        rnd = rnd ^ (rnd << 5);
        return rnd;
    endfunction : next_rand
    function automatic int nbits();
        return frame_mode[1] ? 11 : 10;  // modes 2 and 3 carry a ninth bit
    endfunction : nbits
    // expected line bits, lsb first
    function automatic logic [10:0] frame_of(logic [7:0] d, logic n9);
        if (frame_mode[1])
            return {1'b1, n9, d, 1'b0};
        return {2'b01, d, 1'b0};
    endfunction : frame_of
    task automatic check(input logic [10:0] seen, input logic [10:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            fails++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic clear_flags();
        receive_done_clear <= 1'b1;
        transmit_done_clear <= 1'b1;
        @(posedge ref_clk);
        receive_done_clear <= 1'b0;
        transmit_done_clear <= 1'b0;
        @(posedge ref_clk);
        check({8'h00, receive_done_flag, transmit_done_flag, serial_irq}, 11'h000);
    endtask : clear_flags
    // send one byte; a second write during the frame must be ignored
    task automatic do_tx(input logic [7:0] d, input logic n9);
        logic [10:0] got;
        int i;
        fork
            u_remote.recv(nbits(), got);
            begin
                buffer_write <= 1'b1;
                buffer_write_data <= d;
                transmit_ninth_bit <= n9;
                @(posedge ref_clk);
                buffer_write <= 1'b0;
                wait (sending === 1'b1);
                @(posedge ref_clk);
                buffer_write <= 1'b1;
                buffer_write_data <= ~d;
                transmit_ninth_bit <= ~n9;
                @(posedge ref_clk);
                buffer_write <= 1'b0;
            end
        join
        for (i = 0; i < 4 * cpb && transmit_done_flag !== 1'b1; i++)
            @(posedge ref_clk);
        check(got, frame_of(d, n9));
        check({10'h000, transmit_done_flag}, 11'h001);
        clear_flags();
    endtask : do_tx
    // receive one frame; load says whether the port must take it
    task automatic do_rx(input logic [7:0] d, input logic n9, input logic load, input int hit);
        int i;
        logic was;
        was = receive_done_flag;
        u_remote.send(nbits(), frame_of(d, n9), hit);
        for (i = 0; i < 2 * cpb && receive_done_flag !== 1'b1; i++)
            @(posedge ref_clk);
        if (load)
            exp_rx = {frame_mode[1] ? n9 : 1'b1, d};
        check({2'b00, received_ninth_bit, serial_data_buffer}, {2'b00, exp_rx});
        check({10'h000, receive_done_flag}, {10'h000, load | was});
        repeat (2 * cpb) @(posedge ref_clk);  // search resumes within this gap
    endtask : do_rx
    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : end_of_test
    // -----
    // main sequence
    // -----
    initial begin
        logic [31:0] r;
        repeat (12) @(posedge ref_clk);
        rst <= 1'b0;
        @(posedge ref_clk);
        check({3'h0, serial_data_buffer}, 11'h000);
        check({7'h00, txd, receive_done_flag, transmit_done_flag, serial_irq}, 11'h008);
        for (int m = 0; m < 5; m++) begin
            {frame_mode, double_rate, use_timer2} <= cfg_tab[m];
            address_filter_enable <= (m == 3);  // stop bit 1 passes the filter
            cpb = (cfg_tab[m][1] || cfg_tab[m][0]) ? 8'h10 : 8'h20;
            repeat (2) @(posedge ref_clk);
            repeat (2) begin
                r = next_rand();
                do_tx(r[7:0], r[8]);
                do_rx(r[15:8], r[16], 1'b1, -1);
                clear_flags();
            end
        end
        {frame_mode, double_rate, use_timer2} <= 4'ha;
        cpb = 8'h10;
        address_filter_enable <= 1'b1;
        @(posedge ref_clk);
        do_rx(8'h5a, 1'b0, 1'b0, -1);
        do_rx(8'ha5, 1'b1, 1'b1, -1);
        do_rx(8'h3c, 1'b1, 1'b0, -1);
        clear_flags();
        address_filter_enable <= 1'b0;
        cpb = 8'h04;                   // low glitch that ends before the sample points
        u_remote.send(1, 11'h000, -1);
        cpb = 8'h10;
        repeat (32) @(posedge ref_clk);
        do_rx(8'hc3, 1'b0, 1'b1, 7);
        clear_flags();
        receive_enable <= 1'b0;
        do_rx(8'h77, 1'b1, 1'b0, -1);
        receive_enable <= 1'b1;
        end_of_test();
    end
    // hang guard, about eight times the expected run
    initial begin
        repeat (60000) @(posedge ref_clk);
        fails++;
        end_of_test();
    end
endmodule : tb_top
